// file: tb_touch_conversion_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_touch_conversion_config_regs;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic fetch_i = 1'b0;
  logic start_i = 1'b0;
  logic aux_i = 1'b0;
  logic pen_i = 1'b0;
  logic [3:0] lat = 4'h2;
  logic [7:0] rdata;
  logic [15:0] result;
  logic [2:0] chan;
  logic [11:0] adata;
  logic [1:0] pull;
  logic bias_en, astart, adone, five, aux_an, busy, irq_b;
  logic [15:0] v;
  int failures = 0;
  int check_count = 0;
  always #2 clk_i = ~clk_i;
  tcc_conv_ctrl #(.CLK_KHZ(25000)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr_i),
    .reg_rd_i(rd_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .fetch_result_cmd_i(fetch_i), .result_o(result), .manual_start_i(start_i),
    .aux_pin_i(aux_i), .pen_touch_i(pen_i), .bias_chan_o(chan), .bias_en_o(bias_en),
    .adc_start_o(astart), .adc_done_i(adone), .adc_data_i(adata),
    .pen_detect_pullup_sel_o(pull), .five_wire_o(five), .aux_analog_o(aux_an),
    .busy_o(busy), .irq_b_o(irq_b));
  tcc_adc_model adc (.clk_i(clk_i), .start_i(astart), .bias_en_i(bias_en), .chan_i(chan),
    .lat_i(lat), .done_o(adone), .data_o(adata));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tk(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    tk();
    wr_i = 1'b1;
    addr = a;
    wdata = d;
    tk();
    wr_i = 1'b0;
  endtask : wr
  task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
    tk();
    rd_i = 1'b1;
    addr = a;
    tk();
    rd_i = 1'b0;
    chk(nm, {8'h00, e}, {8'h00, rdata});
  endtask : rc
  task automatic fetch(output logic [15:0] d);
    tk();
    fetch_i = 1'b1;
    tk();
    fetch_i = 1'b0;
    d = result;
  endtask : fetch
  task automatic waitb(input logic l, input int n);
    for (int i = 0; i < n && busy !== l; i++)
      tk();
    if (busy !== l)
    begin
      failures++;
      $display("[FAIL] busy expected %b seen %b", l, busy);
      give_verdict();
    end
  endtask : waitb
  task automatic quiet(input int n);
    int hits = 0;
    repeat (n)
    begin
      tk();
      if (busy !== 1'b0)
        hits++;
    end
    chk("idle", 16'h0000, 16'(hits));
  endtask : quiet
  task automatic run;
    tk();
    start_i = 1'b1;
    tk();
    start_i = 1'b0;
    waitb(1'b1, 4);
    waitb(1'b0, 20000);
    tk(2);
  endtask : run
  task automatic s_reset;
    rc("scan", 5'h00, 8'h00);
    rc("acq", 5'h01, 8'h20);
    rc("filt", 5'h02, 8'h00);
    rc("mask", 5'h04, 8'hC0);
    rc("stat", 5'h05, 8'h20);
    rc("srst", 5'h1F, 8'h00);
  endtask : s_reset
  task automatic s_cfg;
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      wr(5'h01, {c, 1'b1, c[0], c, 2'b00});
      tk();
      chk("pull", {14'h0000, c}, {14'h0000, pull});
      chk("five", {15'h0000, c[0]}, {15'h0000, five});
      chk("auxan", {15'h0000, c == 2'b00}, {15'h0000, aux_an});
    end
    wr(5'h01, 8'h00);
  endtask : s_cfg
  task automatic s_order;
    pen_i = 1'b1;
    wr(5'h04, 8'hF8);
    run();
    chk("irq", 16'h0000, {15'h0000, irq_b});
    for (int c = 0; c < 5; c++)
    begin
      fetch(v);
      chk("result", {5'h00, c[2:0], 8'h3C}, v);
    end
    fetch(v);
    chk("empty", 16'hFFFF, v);
    wr(5'h04, 8'h40);
    run();
    fetch(v);
    chk("y", 16'h013C, v);
    fetch(v);
    chk("empty", 16'hFFFF, v);
  endtask : s_order
  task automatic s_pen;
    wr(5'h04, 8'h80);
    pen_i = 1'b0;
    rc("stat", 5'h05, 8'h40);
    tk(2);
    chk("irq", 16'h0001, {15'h0000, irq_b});
    run();
    chk("irq", 16'h0000, {15'h0000, irq_b});
    fetch(v);
    chk("nopen", 16'hFFFF, v);
    wr(5'h01, 8'h20);
    run();
    chk("irq", 16'h0001, {15'h0000, irq_b});
    pen_i = 1'b1;
  endtask : s_pen
  task automatic s_filter;
    int n0;
    int taps[4] = '{1, 3, 5, 7};
    lat = 4'h9;
    for (int f = 0; f < 4; f++)
    begin
      wr(5'h01, {6'b001000, f[1:0]});
      n0 = adc.starts;
      run();
      chk("samples", 16'(taps[f]), 16'(adc.starts - n0));
      fetch(v);
      chk("avg", 16'h003C, v);
    end
    lat = 4'h2;
    wr(5'h00, 8'h04);
    wr(5'h01, 8'h21);
    adc.gaps.delete();
    run();
    chk("bias", 16'h0001, {15'h0000, adc.gaps[0] inside {[200:250]}});
    chk("settle", 16'h0001, {15'h0000, adc.gaps[1] < 30});
    wr(5'h00, 8'h00);
  endtask : s_filter
  task automatic s_aux;
    wr(5'h01, 8'h60);
    aux_i = 1'b1;
    waitb(1'b1, 10);
    waitb(1'b0, 20000);
    aux_i = 1'b0;
    quiet(20);
    wr(5'h01, 8'h70);
    aux_i = 1'b1;
    quiet(20);
    wr(5'h01, 8'hA0);
    aux_i = 1'b0;
    waitb(1'b1, 10);
    waitb(1'b0, 20000);
    wr(5'h01, 8'hE0);
    aux_i = 1'b1;
    waitb(1'b1, 10);
    waitb(1'b0, 20000);
    aux_i = 1'b0;
    waitb(1'b1, 10);
    waitb(1'b0, 20000);
  endtask : s_aux
  task automatic s_auto;
    int t;
    wr(5'h01, 8'h20);
    wr(5'h00, 8'hF0);
    waitb(1'b1, 20);
    waitb(1'b0, 20000);
    for (t = 0; t < 8000 && busy !== 1'b1; t++)
      tk();
    chk("period", 16'h0001, {15'h0000, t inside {[3900:6000]}});
    wr(5'h00, 8'h00);
    waitb(1'b0, 20000);
    quiet(6000);
  endtask : s_auto
  task automatic s_srst;
    wr(5'h00, 8'h07);
    wr(5'h1F, 8'h55);
    rc("kept", 5'h00, 8'h07);
    wr(5'h04, 8'h18);
    wr(5'h01, 8'h13);
    wr(5'h1F, 8'hDE);
    tk();
    rc("scan", 5'h00, 8'h00);
    rc("mask", 5'h04, 8'hC0);
    rc("acq", 5'h01, 8'h20);
    rc("stat", 5'h05, 8'h20);
    // pin reset while idle: interrupt held low, released one edge later
    wr(5'h04, 8'h18);
    rst_b_i = 1'b0;
    tk();
    chk("irq_rst", 16'h0000, {15'h0000, irq_b});
    chk("res_rst", 16'hFFFF, result);
    rst_b_i = 1'b1;
    tk();
    chk("irq_up", 16'h0001, {15'h0000, irq_b});
    rc("mask", 5'h04, 8'hC0);
  endtask : s_srst
  initial
  begin
    tk(5);
    rst_b_i = 1'b1;
    s_reset();
    s_cfg();
    s_order();
    s_pen();
    s_filter();
    s_aux();
    s_auto();
    s_srst();
    give_verdict();
  end
endmodule : tb_touch_conversion_config_regs
`default_nettype wire

// file: tcc_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_adc_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic bias_en_i,
  input wire logic [2:0] chan_i,
  input wire logic [3:0] lat_i,
  output logic done_o,
  output logic [11:0] data_o
);
  int starts = 0;
  int gap = 0;
  int gaps[$];
  int left = -1;
  initial
  begin
    done_o = 1'b0;
    data_o = 12'h000;
  end
  // data toggles outside done so stale values read inverted on every other cycle
  always @(posedge clk_i)
  begin
    gap <= (done_o || !bias_en_i) ? 0 : gap + 1;
    done_o <= 1'b0;
    data_o <= ~data_o;
    left <= (left > 0) ? left - 1 : -1;
    if (start_i)
    begin
      starts <= starts + 1;
      gaps.push_back(gap);
      left <= lat_i;
    end
    else if (left == 0)
    begin
      done_o <= 1'b1;
      data_o <= {1'b0, chan_i, 8'h3C};
    end
  end
endmodule : tcc_adc_model
`default_nettype wire

// file: tcc_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module tcc_conv_ctrl #(
  parameter int unsigned CLK_KHZ = `TCC_CLK_KHZ,
  parameter int unsigned QDEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic fetch_result_cmd_i,
  output logic [15:0] result_o,
  input wire logic manual_start_i,
  input wire logic aux_pin_i,
  input wire logic pen_touch_i,
  output logic [2:0] bias_chan_o,
  output logic bias_en_o,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [11:0] adc_data_i,
  output logic [1:0] pen_detect_pullup_sel_o,
  output logic five_wire_o,
  output logic aux_analog_o,
  output logic busy_o,
  output logic irq_b_o
);
  localparam int unsigned DLY_NS [16] = `TCC_DLY_NS_TABLE;
  localparam int unsigned RATE_CPS [16] = `TCC_RATE_CPS_TABLE;

  // least time: round up, never below one cycle
  function automatic logic [31:0] dly_cyc(input logic [3:0] code);
    longint unsigned c;
    c = (longint'(DLY_NS[code]) * CLK_KHZ + 999_999) / 1_000_000;
    if (c == 0)
    begin
      c = 1;
    end
    return c[31:0];
  endfunction : dly_cyc

  function automatic logic [31:0] rate_cyc(input logic [3:0] code);
    longint unsigned c;
    c = (longint'(CLK_KHZ) * 1000) / RATE_CPS[code];
    return c[31:0];
  endfunction : rate_cyc

  function automatic tcc_pkg::tcc_chan_t next_chan(input logic [4:0] en, input logic [2:0] from);
    tcc_pkg::tcc_chan_t r;
    r = tcc_pkg::TCC_CH_NONE;
    for (int i = 4; i >= 0; i--)
    begin
      if (en[4-i] && (3'(i) >= from))
      begin
        r = tcc_pkg::tcc_chan_t'(3'(i));
      end
    end
    return r;
  endfunction : next_chan

  logic [7:0] scan_timing_ctrl_r;
  logic [7:0] acquisition_cfg_r;
  logic [7:0] filter_timing_ctrl_r;
  logic [7:0] channel_select_mask_r;
  logic stat_conv_r;
  logic stat_pen_r;
  logic stat_rst_r;
  logic srst_r;
  logic [3:0] rate;
  logic [3:0] bias_settle_delay;
  logic [3:0] filter_settle_delay;
  logic [1:0] extra_input_trigger_sel;
  logic conditional_irq_en;
  logic [1:0] filt;
  logic horizontal_sample_en;
  logic vertical_sample_en;
  logic [4:0] chan_en;

  assign rate = scan_timing_ctrl_r[`TCC_RATE_MSB:`TCC_RATE_LSB];
  assign bias_settle_delay = scan_timing_ctrl_r[`TCC_DLY_MSB:0];
  assign filter_settle_delay = filter_timing_ctrl_r[`TCC_DLY_MSB:0];
  assign extra_input_trigger_sel = acquisition_cfg_r[`TCC_AUX_MSB:`TCC_AUX_LSB];
  assign conditional_irq_en = acquisition_cfg_r[`TCC_COND_BIT];
  assign filt = acquisition_cfg_r[`TCC_FILT_MSB:0];
  assign horizontal_sample_en = channel_select_mask_r[7];
  assign vertical_sample_en = channel_select_mask_r[6];
  assign chan_en = channel_select_mask_r[7:3];

  logic wr_ok;
  assign wr_ok = reg_wr_i && !srst_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      srst_r <= 1'b0;
    end
    else
    begin
      srst_r <= wr_ok && (reg_addr_i == `TCC_OFS_SRST) && (reg_wdata_i == `TCC_SRST_KEY);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scan_timing_ctrl_r <= `TCC_RST_SCAN;
      acquisition_cfg_r <= `TCC_RST_ACQ;
      filter_timing_ctrl_r <= `TCC_RST_FILT;
      channel_select_mask_r <= `TCC_RST_MASK;
    end
    else if (srst_r)
    begin
      scan_timing_ctrl_r <= `TCC_RST_SCAN;
      acquisition_cfg_r <= `TCC_RST_ACQ;
      filter_timing_ctrl_r <= `TCC_RST_FILT;
      channel_select_mask_r <= `TCC_RST_MASK;
    end
    else if (wr_ok)
    begin
      case (reg_addr_i)
        `TCC_OFS_SCAN: scan_timing_ctrl_r <= reg_wdata_i;
        `TCC_OFS_ACQ: acquisition_cfg_r <= reg_wdata_i;
        // upper nibble is reserved
        `TCC_OFS_FILT: filter_timing_ctrl_r <= {4'h0, reg_wdata_i[3:0]};
        // low three bits are reserved
        `TCC_OFS_MASK: channel_select_mask_r <= {reg_wdata_i[7:3], 3'h0};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TCC_OFS_SCAN: reg_rdata_o <= scan_timing_ctrl_r;
        `TCC_OFS_ACQ: reg_rdata_o <= acquisition_cfg_r;
        `TCC_OFS_FILT: reg_rdata_o <= filter_timing_ctrl_r;
        `TCC_OFS_MASK: reg_rdata_o <= channel_select_mask_r;
        `TCC_OFS_STAT: reg_rdata_o <= {stat_conv_r, stat_pen_r, stat_rst_r, 5'h00};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign pen_detect_pullup_sel_o = acquisition_cfg_r[`TCC_PULL_MSB:`TCC_PULL_LSB];
  assign five_wire_o = acquisition_cfg_r[`TCC_SCREEN_BIT];
  assign aux_analog_o = (extra_input_trigger_sel == 2'h0);

  // pins from outside the clock domain
  logic aux_s1_r;
  logic aux_s2_r;
  logic aux_s3_r;
  logic pen_s1_r;
  logic pen_s2_r;
  logic pen_s3_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {aux_s1_r, aux_s2_r, aux_s3_r} <= 3'h0;
      {pen_s1_r, pen_s2_r, pen_s3_r} <= 3'h0;
    end
    else
    begin
      {aux_s1_r, aux_s2_r, aux_s3_r} <= {aux_pin_i, aux_s1_r, aux_s2_r};
      {pen_s1_r, pen_s2_r, pen_s3_r} <= {pen_touch_i, pen_s1_r, pen_s2_r};
    end
  end

  logic aux_edge;
  logic aux_trig;
  always_comb
  begin
    case (extra_input_trigger_sel)
      2'h1: aux_edge = aux_s2_r && !aux_s3_r;
      2'h2: aux_edge = !aux_s2_r && aux_s3_r;
      2'h3: aux_edge = aux_s2_r ^ aux_s3_r;
      default: aux_edge = 1'b0;
    endcase
  end
  assign aux_trig = aux_edge && (rate == 4'h0) && !five_wire_o;

  // interval timer for automatic mode
  logic [31:0] rate_cnt_r;
  logic rate_tick;
  assign rate_tick = (rate != 4'h0) && (rate_cnt_r == 32'h0000_0000);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rate_cnt_r <= 32'h0000_0000;
    end
    else if (srst_r || rate == 4'h0)
    begin
      rate_cnt_r <= 32'h0000_0000;
    end
    else if (rate_tick)
    begin
      rate_cnt_r <= rate_cyc(rate) - 32'h0000_0001;
    end
    else
    begin
      rate_cnt_r <= rate_cnt_r - 32'h0000_0001;
    end
  end

  tcc_pkg::tcc_state_t st_r;
  tcc_pkg::tcc_chan_t ch_r;
  logic [31:0] dly_cnt_r;
  logic [2:0] samp_r;
  logic [14:0] sum_r;
  logic [11:0] max1_r;
  logic [11:0] max2_r;
  logic [11:0] min1_r;
  logic [11:0] min2_r;
  logic pen_ok_r;
  logic seq_pen_r;
  logic [2:0] nsamp;
  logic seq_start;
  tcc_pkg::tcc_chan_t first_ch;
  tcc_pkg::tcc_chan_t after_ch;

  assign nsamp = (filt == 2'h0) ? 3'h1 : {filt, 1'b1};
  assign seq_start = (st_r == tcc_pkg::TCC_IDLE) && !srst_r
    && (rate_tick || (rate == 4'h0 && (manual_start_i || aux_trig)));
  assign first_ch = next_chan(chan_en, 3'h0);
  assign after_ch = next_chan(chan_en, 3'(ch_r) + 3'h1);
  assign busy_o = (st_r != tcc_pkg::TCC_IDLE);
  assign bias_en_o = busy_o && (st_r != tcc_pkg::TCC_DONE);
  assign bias_chan_o = ch_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= tcc_pkg::TCC_IDLE;
      ch_r <= tcc_pkg::TCC_CH_NONE;
      dly_cnt_r <= 32'h0000_0000;
      samp_r <= 3'h0;
      adc_start_o <= 1'b0;
    end
    else if (srst_r)
    begin
      st_r <= tcc_pkg::TCC_IDLE;
      ch_r <= tcc_pkg::TCC_CH_NONE;
      dly_cnt_r <= 32'h0000_0000;
      samp_r <= 3'h0;
      adc_start_o <= 1'b0;
    end
    else
    begin
      adc_start_o <= 1'b0;
      case (st_r)
        tcc_pkg::TCC_IDLE:
        begin
          if (seq_start)
          begin
            ch_r <= first_ch;
            samp_r <= 3'h0;
            dly_cnt_r <= dly_cyc(bias_settle_delay);
            st_r <= (first_ch == tcc_pkg::TCC_CH_NONE) ? tcc_pkg::TCC_DONE
                                                         : tcc_pkg::TCC_SETTLE;
          end
        end
        tcc_pkg::TCC_SETTLE:
        begin
          if (dly_cnt_r <= 32'h0000_0001)
          begin
            st_r <= tcc_pkg::TCC_CONV;
          end
          dly_cnt_r <= dly_cnt_r - 32'h0000_0001;
        end
        tcc_pkg::TCC_CONV:
        begin
          adc_start_o <= 1'b1;
          st_r <= tcc_pkg::TCC_WAIT;
        end
        tcc_pkg::TCC_WAIT:
        begin
          if (adc_done_i)
          begin
            samp_r <= samp_r + 3'h1;
            if (samp_r + 3'h1 >= nsamp)
            begin
              st_r <= tcc_pkg::TCC_STORE;
            end
            else
            begin
              dly_cnt_r <= dly_cyc(filter_settle_delay);
              st_r <= tcc_pkg::TCC_SETTLE;
            end
          end
        end
        tcc_pkg::TCC_STORE:
        begin
          samp_r <= 3'h0;
          ch_r <= after_ch;
          dly_cnt_r <= dly_cyc(bias_settle_delay);
          st_r <= (after_ch == tcc_pkg::TCC_CH_NONE) ? tcc_pkg::TCC_DONE
                                                       : tcc_pkg::TCC_SETTLE;
        end
        tcc_pkg::TCC_DONE:
        begin
          ch_r <= tcc_pkg::TCC_CH_NONE;
          st_r <= tcc_pkg::TCC_IDLE;
        end
        default: st_r <= tcc_pkg::TCC_IDLE;
      endcase
    end
  end

  // running sum plus two largest and two smallest for the median-3 mode
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sum_r <= 15'h0000;
      {max1_r, max2_r, min1_r, min2_r} <= {24'h00_0000, 24'hFF_FFFF};
      pen_ok_r <= 1'b1;
    end
    else if (st_r != tcc_pkg::TCC_WAIT && samp_r == 3'h0)
    begin
      sum_r <= 15'h0000;
      {max1_r, max2_r, min1_r, min2_r} <= {24'h00_0000, 24'hFF_FFFF};
      pen_ok_r <= 1'b1;
    end
    else if (st_r == tcc_pkg::TCC_WAIT && adc_done_i)
    begin
      sum_r <= sum_r + {3'h0, adc_data_i};
      pen_ok_r <= pen_ok_r && pen_s2_r;
      if (adc_data_i >= max1_r)
      begin
        max2_r <= max1_r;
        max1_r <= adc_data_i;
      end
      else if (adc_data_i > max2_r)
      begin
        max2_r <= adc_data_i;
      end
      if (adc_data_i <= min1_r)
      begin
        min2_r <= min1_r;
        min1_r <= adc_data_i;
      end
      else if (adc_data_i < min2_r)
      begin
        min2_r <= adc_data_i;
      end
    end
  end

  logic [14:0] mid_sum;
  logic [15:0] filt_val;
  logic [15:0] q_wdata;
  assign mid_sum = sum_r - {3'h0, max1_r} - {3'h0, max2_r} - {3'h0, min1_r} - {3'h0, min2_r};

  always_comb
  begin
    case (filt)
      2'h1: filt_val = {1'b0, sum_r / 15'h0003};
      2'h2: filt_val = {1'b0, sum_r / 15'h0005};
      2'h3: filt_val = {1'b0, mid_sum / 15'h0003};
      default: filt_val = {1'b0, sum_r};
    endcase
  end
  assign q_wdata = pen_ok_r ? filt_val : `TCC_INVALID;

  // result queue, cleared when a new sequence starts
  logic [2:0] wr_ptr_r;
  logic [2:0] rd_ptr_r;
  logic q_empty;
  logic empty_q_r;
  logic q_push;
  logic q_pop;
  logic [15:0] mem_rdata;
  assign q_empty = (wr_ptr_r == rd_ptr_r);
  assign q_push = (st_r == tcc_pkg::TCC_STORE);
  assign q_pop = fetch_result_cmd_i && !q_empty;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      empty_q_r <= 1'b1;
    end
    else if (srst_r || seq_start)
    begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      empty_q_r <= 1'b1;
    end
    else
    begin
      if (q_push)
      begin
        wr_ptr_r <= wr_ptr_r + 3'h1;
      end
      if (fetch_result_cmd_i)
      begin
        empty_q_r <= q_empty;
      end
      if (q_pop)
      begin
        rd_ptr_r <= rd_ptr_r + 3'h1;
      end
    end
  end

  tcc_result_mem #(
    .WIDTH(16),
    .DEPTH(QDEPTH),
    .AW(3)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(q_push),
    .wr_addr_i(wr_ptr_r),
    .wr_data_i(q_wdata),
    .rd_en_i(q_pop),
    .rd_addr_i(rd_ptr_r),
    .rd_data_o(mem_rdata)
  );
  assign result_o = empty_q_r ? `TCC_INVALID : mem_rdata;

  // status flags: hardware set wins over the read-clear
  logic stat_rd;
  assign stat_rd = reg_rd_i && (reg_addr_i == `TCC_OFS_STAT);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stat_conv_r <= 1'b0;
      stat_pen_r <= 1'b0;
      stat_rst_r <= 1'b1;
      seq_pen_r <= 1'b1;
      irq_b_o <= 1'b0;
    end
    else if (srst_r)
    begin
      stat_conv_r <= 1'b0;
      stat_pen_r <= 1'b0;
      stat_rst_r <= 1'b1;
      seq_pen_r <= 1'b1;
      irq_b_o <= 1'b1;
    end
    else
    begin
      if (seq_start)
      begin
        seq_pen_r <= 1'b1;
      end
      else if (q_push && !pen_ok_r)
      begin
        seq_pen_r <= 1'b0;
      end
      if (st_r == tcc_pkg::TCC_DONE && (!conditional_irq_en || seq_pen_r))
      begin
        stat_conv_r <= 1'b1;
      end
      else if (fetch_result_cmd_i)
      begin
        stat_conv_r <= 1'b0;
      end
      if (pen_s2_r && !pen_s3_r)
      begin
        stat_pen_r <= 1'b1;
      end
      else if (stat_rd)
      begin
        stat_pen_r <= 1'b0;
      end
      if (stat_rd)
      begin
        stat_rst_r <= 1'b0;
      end
      irq_b_o <= !(stat_conv_r || stat_pen_r);
    end
  end

  a_empty_invalid: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (fetch_result_cmd_i && q_empty && !srst_r) |=> (result_o == 16'hFFFF))
    else $error("empty queue fetch not invalid");
  a_nopen_invalid: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_r == tcc_pkg::TCC_WAIT && adc_done_i && !pen_s2_r && !srst_r)
    |=> (!pen_ok_r && (!q_push || q_wdata == 16'hFFFF)))
    else $error("pen-less conversion stored a value");
  a_manual_no_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rate == 4'h0 && st_r == tcc_pkg::TCC_IDLE && !manual_start_i && !aux_trig)
    |=> (st_r == tcc_pkg::TCC_IDLE) || srst_r)
    else $error("sequence started without trigger in manual mode");
  a_rate_spacing: assert property (@(posedge clk_i) disable iff (!rst_b_i || srst_r)
    (rate_tick && $stable(rate)) |=> !rate_tick[*2])
    else $error("timer ticks too close");
  a_settle_before: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    adc_start_o |-> $past(st_r, 2) == tcc_pkg::TCC_SETTLE)
    else $error("conversion without settle");
  a_aux_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (aux_edge && five_wire_o && rate == 4'h0 && !manual_start_i
     && st_r == tcc_pkg::TCC_IDLE && !srst_r) |=> (st_r == tcc_pkg::TCC_IDLE))
    else $error("aux edge honoured on five-wire panel");
  a_cond_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_r == tcc_pkg::TCC_DONE && conditional_irq_en && !seq_pen_r && !stat_conv_r
     && !srst_r) |=> !stat_conv_r)
    else $error("conditional interrupt without pen");
  a_mask_x: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (adc_start_o && bias_chan_o == tcc_pkg::TCC_CH_X) |-> $past(horizontal_sample_en, 3))
    else $error("horizontal sampled while masked");
  a_mask_y: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (adc_start_o && bias_chan_o == tcc_pkg::TCC_CH_Y) |-> $past(vertical_sample_en, 3))
    else $error("vertical sampled while masked");
  a_soft_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    srst_r |=> (channel_select_mask_r == 8'hC0 && scan_timing_ctrl_r == 8'h00 && !busy_o))
    else $error("soft reset incomplete");
endmodule : tcc_conv_ctrl
`default_nettype wire

// file: tcc_defs.svh
// What this block does
// - Fetching results after the queue is drained returns 16'hFFFF.
// - A conversion taken without pen contact stores 16'hFFFF instead.
// - Scan rate field 7:4 zero means manual; nonzero means timed operation.
// - Rate codes 1..15 map to 10 up to 5000 coordinates per second.
// - Each channel is biased for the bias delay of bits 3:0 first.
// - Trigger field 7:6: analogue input, rising, falling or both aux edges.
// - Aux edges trigger only in manual mode with a four-wire panel.
// - Conditional bit 5 clear: always interrupt; set: only when pen seen.
// - Bit 4 of second control register selects four- or five-wire panel.
// - Bits 3:2 select the pen-detect pull-up resistor value.
// - Bits 1:0 select no filter, average 3, average 5, median-3 of 7.
// - Later conversions of a filter set use the filter settle delay.
// - Mask bit 7 enables the horizontal channel, set after reset.
// - Mask bit 6 enables the vertical channel, set after reset.
// - Results queue in order X, Y, Z1, Z2, AUX; each read pops once.
// - Writing 8'hDE to the soft reset register resets the registers, sequencer, queue and status flags.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_OFS_SCAN 5'h00
`define TCC_OFS_ACQ 5'h01
`define TCC_OFS_FILT 5'h02
`define TCC_OFS_MASK 5'h04
`define TCC_OFS_STAT 5'h05
`define TCC_OFS_SRST 5'h1F
`define TCC_SRST_KEY 8'hDE
`define TCC_RST_SCAN 8'h00
`define TCC_RST_ACQ 8'h20
`define TCC_RST_FILT 8'h00
`define TCC_RST_MASK 8'hC0
`define TCC_INVALID 16'hFFFF
`define TCC_RATE_MSB 7
`define TCC_RATE_LSB 4
`define TCC_DLY_MSB 3
`define TCC_AUX_MSB 7
`define TCC_AUX_LSB 6
`define TCC_COND_BIT 5
`define TCC_SCREEN_BIT 4
`define TCC_PULL_MSB 3
`define TCC_PULL_LSB 2
`define TCC_FILT_MSB 1
`define TCC_STAT_CONV 7
`define TCC_STAT_PEN 6
`define TCC_STAT_RST 5
// settle times in ns, codes 0..15
`define TCC_DLY_NS_TABLE '{500, 1100, 2200, 4400, 8900, 17800, 35500, 71000, 140000, \
  280000, 570000, 1140000, 2270000, 4550000, 9090000, 18190000}
// scan rates in coordinates per second, codes 0..15 (code 0 unused)
`define TCC_RATE_CPS_TABLE '{1, 10, 20, 40, 60, 80, 100, 200, 300, 400, 500, 1000, \
  2000, 3000, 4000, 5000}
`define TCC_CLK_KHZ 250000
`endif

// file: tcc_pkg.sv
package tcc_pkg;
  typedef enum logic [5:0] {
    TCC_IDLE = 6'h01,
    TCC_SETTLE = 6'h02,
    TCC_CONV = 6'h04,
    TCC_WAIT = 6'h08,
    TCC_STORE = 6'h10,
    TCC_DONE = 6'h20
  } tcc_state_t;
  typedef enum logic [2:0] {
    TCC_CH_X = 3'h0,
    TCC_CH_Y = 3'h1,
    TCC_CH_Z1 = 3'h2,
    TCC_CH_Z2 = 3'h3,
    TCC_CH_AUX = 3'h4,
    TCC_CH_NONE = 3'h5
  } tcc_chan_t;
endpackage : tcc_pkg

// file: tcc_result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_result_mem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = 3
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rd_en_i)
    begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end
endmodule : tcc_result_mem
`default_nettype wire
